// >>> src/kbdc_cfg_top.sv
// Configuration register for the keyboard controller lines and interrupts.
// Assumes a same-clock register master and asynchronous keyboard/mouse pins.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bit 7 picks aux line polarity, default low
// - Bit 6 blocks mouse lines into core
// - Mouse data always reaches wake-up logic
// - Bit 5 blocks keyboard lines into core
// - Keyboard data always reaches wake-up logic
// - Bit 4 low: mouse irq raw AND latched
// - Bit 4 high: mouse irq is latched copy
module kbdc_cfg_top
  import kbdc_cfg_pkg::*;
(
  input wire logic SYS_CLK,                      // 40 MHz system clock
  input wire logic RST_B,                        // Async reset, active low
  input wire logic [KBDC_ADDR_W-1:0] REG_ADDR,   // Register address
  input wire logic [KBDC_DATA_W-1:0] REG_WDATA,  // Write data
  input wire logic REG_WR,                       // Write strobe
  input wire logic REG_RD,                       // Read strobe
  output logic [KBDC_DATA_W-1:0] REG_RDATA,      // Read data, next cycle
  input wire logic CORE_AUX_PORT,                // Core aux line, 1=asserted
  input wire logic CORE_MOUSE_IRQ,               // Core raw mouse interrupt
  input wire logic CORE_MOUSE_IRQ_CLR,           // Clears latched mouse irq
  input wire logic CORE_KBD_IRQ,                 // Core raw keyboard irq
  input wire logic CORE_KBD_IRQ_CLR,             // Clears latched kbd irq
  input wire logic MOUSE_CLK_IN,                 // Mouse clock pin level
  input wire logic MOUSE_DATA_IN,                // Mouse data pin level
  input wire logic KBD_CLK_IN,                   // Keyboard clock pin level
  input wire logic KBD_DATA_IN,                  // Keyboard data pin level
  output logic AUX_OUTPUT_PORT_LINE,             // Aux line after polarity
  output logic CORE_MOUSE_CLK,                   // Mouse clock into core
  output logic CORE_MOUSE_DATA,                  // Mouse data into core
  output logic CORE_KBD_CLK,                     // Keyboard clock into core
  output logic CORE_KBD_DATA,                    // Keyboard data into core
  output logic MOUSE_WAKE_DATA,                  // Mouse data to wake logic
  output logic KBD_WAKE_DATA,                    // Kbd data to wake logic
  output logic MOUSE_IRQ,                        // Mouse interrupt out
  output logic KBD_IRQ,                          // Keyboard interrupt out
  output logic PORT92_EN                         // Port 92 enable
);

  typedef struct packed {
    logic [KBDC_DATA_W-1:0] cfg;
    logic [KBDC_DATA_W-1:0] rdata;
    logic aux_line;
    logic m_clk;
    logic m_dat;
    logic k_clk;
    logic k_dat;
    logic m_wake;
    logic k_wake;
    logic p92;
  } kbdc_top_s;

  kbdc_top_s st_reg;
  kbdc_top_s st_next;

  logic [3:0] pin_sync;
  logic m_clk_s;
  logic m_dat_s;
  logic k_clk_s;
  logic k_dat_s;
  logic cfg_hit;

  // Polarity apply: asserted core level to pin level
  function automatic logic kbdc_polar(input logic asserted,
                                      input logic act_high);
    kbdc_polar = act_high ? asserted : ~asserted;
  endfunction : kbdc_polar

  // Isolation: blocked lines sit at the idle level
  function automatic logic kbdc_iso(input logic level, input logic block);
    kbdc_iso = block ? KBDC_ISO_LEVEL : level;
  endfunction : kbdc_iso

  kbdc_sync2 #(
    .WIDTH(KBDC_SYNC_STAGES * 2)
  ) u_pin_sync (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .d({MOUSE_CLK_IN, MOUSE_DATA_IN, KBD_CLK_IN, KBD_DATA_IN}),
    .q(pin_sync)
  );

  assign m_clk_s = pin_sync[3];
  assign m_dat_s = pin_sync[2];
  assign k_clk_s = pin_sync[1];
  assign k_dat_s = pin_sync[0];
  assign cfg_hit = (REG_ADDR == KBDC_CFG_OFS);

  always_comb begin
    st_next = st_reg;
    // Reserved bits are never stored, so they read as zero
    if (REG_WR && cfg_hit) begin
      st_next.cfg = REG_WDATA & KBDC_CFG_WMASK;
    end
    // Unmapped and reserved offsets read as zero
    if (REG_RD && cfg_hit) begin
      st_next.rdata = st_reg.cfg;
    end else begin
      st_next.rdata = '0;
    end
    // Paths use the stored value, so a write acts one cycle later
    st_next.aux_line = kbdc_polar(CORE_AUX_PORT,
                                  st_reg.cfg[KBDC_BIT_AUX_POL]);
    st_next.m_clk = kbdc_iso(m_clk_s, st_reg.cfg[KBDC_BIT_MOUSE_ISO]);
    st_next.m_dat = kbdc_iso(m_dat_s, st_reg.cfg[KBDC_BIT_MOUSE_ISO]);
    st_next.k_clk = kbdc_iso(k_clk_s, st_reg.cfg[KBDC_BIT_KBD_ISO]);
    st_next.k_dat = kbdc_iso(k_dat_s, st_reg.cfg[KBDC_BIT_KBD_ISO]);
    // Wake paths bypass isolation so a blocked device can still wake
    st_next.m_wake = m_dat_s;
    st_next.k_wake = k_dat_s;
    st_next.p92 = st_reg.cfg[KBDC_BIT_PORT92];
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg.cfg <= KBDC_CFG_RESET;
      st_reg.rdata <= '0;
      // Default polarity is active low, so idle pin is high
      st_reg.aux_line <= KBDC_LINE_RESET;
      st_reg.m_clk <= KBDC_LINE_RESET;
      st_reg.m_dat <= KBDC_LINE_RESET;
      st_reg.k_clk <= KBDC_LINE_RESET;
      st_reg.k_dat <= KBDC_LINE_RESET;
      st_reg.m_wake <= KBDC_LINE_RESET;
      st_reg.k_wake <= KBDC_LINE_RESET;
      st_reg.p92 <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  kbdc_irq_combine u_mouse_irq (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .raw_irq(CORE_MOUSE_IRQ),
    .clr(CORE_MOUSE_IRQ_CLR),
    .latch_sel(st_reg.cfg[KBDC_BIT_MOUSE_LATCH]),
    .irq_out(MOUSE_IRQ)
  );

  kbdc_irq_combine u_kbd_irq (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .raw_irq(CORE_KBD_IRQ),
    .clr(CORE_KBD_IRQ_CLR),
    .latch_sel(st_reg.cfg[KBDC_BIT_KBD_LATCH]),
    .irq_out(KBD_IRQ)
  );

  assign REG_RDATA = st_reg.rdata;
  assign AUX_OUTPUT_PORT_LINE = st_reg.aux_line;
  assign CORE_MOUSE_CLK = st_reg.m_clk;
  assign CORE_MOUSE_DATA = st_reg.m_dat;
  assign CORE_KBD_CLK = st_reg.k_clk;
  assign CORE_KBD_DATA = st_reg.k_dat;
  assign MOUSE_WAKE_DATA = st_reg.m_wake;
  assign KBD_WAKE_DATA = st_reg.k_wake;
  assign PORT92_EN = st_reg.p92;

  a_aux_pol_low: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !$past(st_reg.cfg[KBDC_BIT_AUX_POL])
      |-> AUX_OUTPUT_PORT_LINE == !$past(CORE_AUX_PORT))
    else $error("aux line not active low with bit 7 clear");

  a_aux_pol_high: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $past(st_reg.cfg[KBDC_BIT_AUX_POL])
      |-> AUX_OUTPUT_PORT_LINE == $past(CORE_AUX_PORT))
    else $error("aux line not active high with bit 7 set");

  a_mouse_iso_path: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CORE_MOUSE_CLK == ($past(st_reg.cfg[KBDC_BIT_MOUSE_ISO]) ?
      KBDC_ISO_LEVEL : $past(m_clk_s)) &&
    CORE_MOUSE_DATA == ($past(st_reg.cfg[KBDC_BIT_MOUSE_ISO]) ?
      KBDC_ISO_LEVEL : $past(m_dat_s)))
    else $error("mouse lines into core wrong for isolate bit");

  a_mouse_wake_path: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ##3 MOUSE_WAKE_DATA == $past(MOUSE_DATA_IN, 3))
    else $error("mouse wake data does not follow the pin");

  a_kbd_iso_path: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    CORE_KBD_CLK == ($past(st_reg.cfg[KBDC_BIT_KBD_ISO]) ?
      KBDC_ISO_LEVEL : $past(k_clk_s)) &&
    CORE_KBD_DATA == ($past(st_reg.cfg[KBDC_BIT_KBD_ISO]) ?
      KBDC_ISO_LEVEL : $past(k_dat_s)))
    else $error("keyboard lines into core wrong for isolate bit");

  a_kbd_wake_path: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ##3 KBD_WAKE_DATA == $past(KBD_DATA_IN, 3))
    else $error("keyboard wake data does not follow the pin");

  a_cfg_write_apply: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (REG_WR && cfg_hit) |=> st_reg.cfg == ($past(REG_WDATA) & KBDC_CFG_WMASK)
      ##1 AUX_OUTPUT_PORT_LINE == kbdc_polar($past(CORE_AUX_PORT),
                                   $past(st_reg.cfg[KBDC_BIT_AUX_POL])))
    else $error("config write not applied one cycle after");

  a_read_slot: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (REG_RD && cfg_hit) |=> REG_RDATA == $past(st_reg.cfg)
      ##1 ($past(REG_RD && cfg_hit) || REG_RDATA == '0))
    else $error("read data not in the single following cycle");

  c_mouse_isolated: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st_reg.cfg[KBDC_BIT_MOUSE_ISO] && !m_dat_s ##1 MOUSE_WAKE_DATA == 1'b0);

  c_kbd_isolated: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st_reg.cfg[KBDC_BIT_KBD_ISO] && !k_dat_s);

  c_aux_high: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st_reg.cfg[KBDC_BIT_AUX_POL] && AUX_OUTPUT_PORT_LINE);

  c_wr_then_rd: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    (REG_WR && cfg_hit) ##1 (REG_RD && cfg_hit));

endmodule : kbdc_cfg_top
`default_nettype wire

// >>> src/kbdc_cfg_pkg.sv
// Constants for the keyboard controller line and interrupt configuration.
// Assumes one 8-bit configuration space reached over a plain strobe port.
package kbdc_cfg_pkg;

  localparam int unsigned KBDC_ADDR_W = 8;
  localparam int unsigned KBDC_DATA_W = 8;

  // Register offset and reset value
  localparam logic [7:0] KBDC_CFG_OFS = 8'hf0;
  localparam logic [7:0] KBDC_CFG_RESET = 8'h00;
  // Bits 1:0 are reserved and read as zero
  localparam logic [7:0] KBDC_CFG_WMASK = 8'hfc;

  // Field positions
  localparam int unsigned KBDC_BIT_AUX_POL = 7;
  localparam int unsigned KBDC_BIT_MOUSE_ISO = 6;
  localparam int unsigned KBDC_BIT_KBD_ISO = 5;
  localparam int unsigned KBDC_BIT_MOUSE_LATCH = 4;
  localparam int unsigned KBDC_BIT_KBD_LATCH = 3;
  localparam int unsigned KBDC_BIT_PORT92 = 2;

  // Level presented to the core while a line is isolated (bus idle)
  localparam logic KBDC_ISO_LEVEL = 1'b1;
  // Reset values of the registered outputs
  localparam logic KBDC_LINE_RESET = 1'b1;
  localparam logic KBDC_IRQ_RESET = 1'b0;
  localparam int unsigned KBDC_SYNC_STAGES = 2;

endpackage : kbdc_cfg_pkg

// >>> src/kbdc_sync2.sv
// Two-stage synchroniser for pin inputs.
// Assumes the pins are asynchronous to SYS_CLK; outputs only stage two.
`timescale 1ns/1ps
`default_nettype none
module kbdc_sync2
  import kbdc_cfg_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,                // System clock
  input wire logic rst_b,              // Async reset, active low
  input wire logic [WIDTH-1:0] d,      // Asynchronous pin levels
  output logic [WIDTH-1:0] q           // Synchronised levels
);

  initial begin
    if (WIDTH < 1) begin
      $error("kbdc_sync2: WIDTH must be at least 1");
    end
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } kbdc_sync_s;

  kbdc_sync_s st_reg;
  kbdc_sync_s st_next;

  always_comb begin
    st_next.s1 = d;
    // Stage one is read by stage two only
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= {(2 * WIDTH){KBDC_LINE_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule : kbdc_sync2
`default_nettype wire

// >>> src/kbdc_irq_combine.sv
// Latches a core interrupt and forms the outgoing interrupt from it.
// Assumes raw_irq and clr come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module kbdc_irq_combine
  import kbdc_cfg_pkg::*;
(
  input wire logic clk,        // System clock
  input wire logic rst_b,      // Async reset, active low
  input wire logic raw_irq,    // Raw interrupt from the core
  input wire logic clr,        // Clears the latched copy, one cycle
  input wire logic latch_sel,  // 1: latched only, 0: raw AND latched
  output logic irq_out         // Registered interrupt output
);

  typedef struct packed {
    logic latched;
    logic out;
  } kbdc_irq_s;

  kbdc_irq_s st_reg;
  kbdc_irq_s st_next;

  always_comb begin
    // Set beats clear so a new request is never lost
    st_next.latched = raw_irq | (st_reg.latched & ~clr);
    if (latch_sel) begin
      st_next.out = st_reg.latched;
    end else begin
      st_next.out = raw_irq & st_reg.latched;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= {KBDC_IRQ_RESET, KBDC_IRQ_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_out = st_reg.out;

  a_irq_and_mode: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(latch_sel) |-> irq_out == ($past(raw_irq) && $past(st_reg.latched)))
    else $error("irq output is not raw AND latched");

  a_irq_latch_mode: assert property (@(posedge clk) disable iff (!rst_b)
    $past(latch_sel) |-> irq_out == $past(st_reg.latched))
    else $error("irq output is not the latched copy");

  a_irq_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
    (raw_irq && clr) |=> st_reg.latched)
    else $error("clear beat a simultaneous set");

  c_irq_latched_out: cover property (@(posedge clk) disable iff (!rst_b)
    latch_sel && irq_out && !raw_irq);

endmodule : kbdc_irq_combine
`default_nettype wire

// >>> verification/kbdc_pin_model.sv
// Keyboard and mouse devices seen as open-drain clock/data lines.
// Assumes the bench commands which lines each device pulls low.
`timescale 1ns/1ps
`default_nettype none
module kbdc_pin_model (
  input wire logic [3:0] pull_low, // mclk, mouse_data_line, kclk, keyboard_data_line
  output logic mouse_clk,          // Mouse clock pin
  output logic mouse_data,         // Mouse data pin
  output logic kbd_clk,            // Keyboard clock pin
  output logic kbd_data            // Keyboard data pin
);
  // Released lines go to the pull-up level, never the last value
  assign mouse_clk = ~pull_low[3];
  assign mouse_data = ~pull_low[2];
  assign kbd_clk = ~pull_low[1];
  assign kbd_data = ~pull_low[0];
endmodule : kbdc_pin_model
`default_nettype wire

// >>> verification/kbdc_cfg_top_bench.sv
// Self-checking bench for the keyboard line and irq configuration block.
// Assumes the pin model on the device lines and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module kbdc_cfg_top_bench;
  import kbdc_cfg_pkg::*;
  logic SYS_CLK;
  logic RST_B;
  logic [7:0] REG_ADDR;
  logic [7:0] REG_WDATA;
  logic REG_WR;
  logic REG_RD;
  logic [7:0] REG_RDATA;
  logic aux_in;
  logic m_irq;
  logic m_clr;
  logic k_irq;
  logic k_clr;
  logic [3:0] pull_low;
  wire logic mclk, mouse_data_line, kclk, keyboard_data_line;
  logic aux_out, cmc, cmd, ckc, ckd, mwk, kwk, mirq, kirq, p92;
  int error_cnt;
  int checked;
  logic [7:0] rdv;

  kbdc_pin_model u_kbdc_pin_model (.pull_low(pull_low), .mouse_clk(mclk),
    .mouse_data(mouse_data_line), .kbd_clk(kclk), .kbd_data(keyboard_data_line));

  kbdc_cfg_top u_kbdc_cfg_top (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CORE_AUX_PORT(aux_in),
    .CORE_MOUSE_IRQ(m_irq), .CORE_MOUSE_IRQ_CLR(m_clr),
    .CORE_KBD_IRQ(k_irq), .CORE_KBD_IRQ_CLR(k_clr),
    .MOUSE_CLK_IN(mclk), .MOUSE_DATA_IN(mouse_data_line), .KBD_CLK_IN(kclk),
    .KBD_DATA_IN(keyboard_data_line), .AUX_OUTPUT_PORT_LINE(aux_out),
    .CORE_MOUSE_CLK(cmc), .CORE_MOUSE_DATA(cmd), .CORE_KBD_CLK(ckc),
    .CORE_KBD_DATA(ckd), .MOUSE_WAKE_DATA(mwk), .KBD_WAKE_DATA(kwk),
    .MOUSE_IRQ(mirq), .KBD_IRQ(kirq), .PORT92_EN(p92));

  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask : rd

  function automatic logic [7:0] lines();
    return {2'b00, cmc, cmd, ckc, ckd, mwk, kwk};
  endfunction : lines

  task automatic test_regs();
    rd(KBDC_CFG_OFS, rdv);
    chk(rdv, 8'h00);
    chk({7'h00, aux_out}, 8'h01);
    wr(8'hf1, 8'hff);
    rd(8'hf1, rdv);
    chk(rdv, 8'h00);
    wr(KBDC_CFG_OFS, 8'hff);
    rd(KBDC_CFG_OFS, rdv);
    chk(rdv, 8'hfc);
    chk({7'h00, p92}, 8'h01);
    step(1);
    chk(REG_RDATA, 8'h00);
    wr(KBDC_CFG_OFS, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_polarity();
    @(posedge SYS_CLK);
    aux_in <= 1'b1;
    step(2);
    chk({7'h00, aux_out}, 8'h00);
    wr(KBDC_CFG_OFS, 8'h80);
    chk({7'h00, aux_out}, 8'h00);
    step(1);
    chk({7'h00, aux_out}, 8'h01);
    aux_in <= 1'b0;
    step(2);
    chk({7'h00, aux_out}, 8'h00);
    wr(KBDC_CFG_OFS, 8'h00);
    $display("test_polarity done");
  endtask : test_polarity

  task automatic test_isolation();
    @(posedge SYS_CLK);
    pull_low <= 4'hf;
    step(4);
    chk(lines(), 8'h00);
    wr(KBDC_CFG_OFS, 8'h40);
    step(1);
    chk(lines(), 8'h30);
    wr(KBDC_CFG_OFS, 8'h20);
    step(1);
    chk(lines(), 8'h0c);
    wr(KBDC_CFG_OFS, 8'h60);
    step(1);
    chk(lines(), 8'h3c);
    pull_low <= 4'h0;
    step(4);
    chk(lines(), 8'h3f);
    wr(KBDC_CFG_OFS, 8'h00);
    $display("test_isolation done");
  endtask : test_isolation

  task automatic test_irq();
    @(posedge SYS_CLK);
    m_irq <= 1'b1;
    step(3);
    chk({7'h00, mirq}, 8'h01);
    m_irq <= 1'b0;
    step(2);
    chk({7'h00, mirq}, 8'h00);
    wr(KBDC_CFG_OFS, 8'h10);
    step(1);
    chk({7'h00, mirq}, 8'h01);
    m_clr <= 1'b1;
    @(posedge SYS_CLK);
    m_clr <= 1'b0;
    step(2);
    chk({7'h00, mirq}, 8'h00);
    chk({7'h00, kirq}, 8'h00);
    // Short keyboard pulse: AND mode hides it, latched mode shows it
    @(posedge SYS_CLK);
    k_irq <= 1'b1;
    @(posedge SYS_CLK);
    k_irq <= 1'b0;
    step(2);
    chk({7'h00, kirq}, 8'h00);
    wr(KBDC_CFG_OFS, 8'h08);
    step(1);
    chk({7'h00, kirq}, 8'h01);
    k_clr <= 1'b1;
    @(posedge SYS_CLK);
    k_clr <= 1'b0;
    step(2);
    chk({7'h00, kirq}, 8'h00);
    wr(KBDC_CFG_OFS, 8'h00);
    $display("test_irq done");
  endtask : test_irq

  task automatic conclude();
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    #(25 * 4000);
    error_cnt++;
    conclude();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    RST_B = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    aux_in = 1'b0;
    m_irq = 1'b0;
    m_clr = 1'b0;
    k_irq = 1'b0;
    k_clr = 1'b0;
    pull_low = 4'h0;
    repeat (12) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    test_regs();
    test_polarity();
    test_isolation();
    test_irq();
    conclude();
  end
endmodule : kbdc_cfg_top_bench
`default_nettype wire
